// >>> rtl/bus_iface_pkg.sv
/*
 * Shared constants for the processor-to-backplane bus interface: clock rate,
 * reply timeout and the address bits that mark the I/O page.
 * Assumes a single 20 MHz system clock and synchronous inputs.
 */
package bus_iface_pkg;
    // System clock period in nanoseconds
    localparam int CLK_PERIOD_NS = 50;
    // Reply timeout in nanoseconds (ten microseconds)
    localparam int REPLY_TIMEOUT_NS = 10000;
    // Timeout in clock cycles, rounded down as a longest time
    localparam int REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_NS / CLK_PERIOD_NS;
    // Local address/data bus width
    localparam int ADDR_W = 16;
    // Lowest address bit of the I/O page decode
    localparam int IO_PAGE_LSB = 13;
    // Pattern of the top three bits that selects the I/O page
    localparam logic [2:0] IO_PAGE_TAG = 3'h7;
    // Cycle states of the write sequence
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ADDR = 2'h1,
        ST_DATA = 2'h3,
        ST_DONE = 2'h2
    } wr_state_t;
endpackage

// >>> rtl/reply_timer.sv
/*
 * Reply timeout counter: counts while a bus strobe waits for a reply and
 * holds expiry high once the count reaches the limit, until run drops.
 * Assumes run is held for the whole wait and cleared by the caller.
 */
`timescale 1ns/1ns
module reply_timer
    import bus_iface_pkg::*;
#(
    parameter int LIMIT = REPLY_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic run,
    output logic expired
);
    // Refuse a limit the counter cannot hold
    initial begin
        if (LIMIT < 1 || LIMIT > 65535) begin
            $error("reply_timer LIMIT out of range");
        end
    end

    // Cycles spent waiting so far
    logic [15:0] count;
    // Limit at counter width
    wire [15:0] limit_w = 16'(LIMIT);

    // Count while waiting, restart when the wait ends
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !run) begin
            count <= 16'h0000;
        end else if (count != limit_w) begin
            count <= count + 16'h0001;
        end
    end

    // Expiry is a level held until the wait is released
    assign expired = run && (count == limit_w);
endmodule

// >>> rtl/bus_iface.sv
/*
 * Bridge between the processor's multiplexed local bus and the asynchronous
 * backplane bus: cycle typing, read/write/byte strobes, reply timeout,
 * transceiver direction and I/O-page select.
 * Assumes all processor strobes and bus inputs are synchronous to clk_sys;
 * backplane outputs are active low and drive open-collector buffers outside.
 */
`timescale 1ns/1ns
// Notes on behaviour
// - Cycle type high for cpu, low otherwise
// - Cycle type loaded from cycle select on strobe
// - Cycle-sync clear forces cycle type low
// - Cycle-sync latch stays low during DMA
// - Both selects high: read flag, BDIN low
// - Intack strobe forces in strobe and BDIN
// - Any select low: write, address-phase BWTBT
// - Selects differ: byte; equal: word
// - Byte/word latched; BWTBT held for bytes
// - Priority-in rise drives out strobe, BDOUT
// - Disable latch blocks BWTBT; cycle-sync clears
// - Either strobe starts reply timeout
// - Timeout error cleared per cycle, not on reply
// - Reply raises received and reply-or-timeout
// - No reply: set timeout error, signal halt
// - Transmit for cpu cycles, receive on reads
// - Bus clear low disables transceivers
// - Intack: high byte off, low byte receives
// - Receive has priority over transmit
// - DMA receives until local decode resolves
// - DMA local: BDIN transmits, BDOUT receives
// - Top 8K page asserts BBS7, io flag
// - Clock stopped until reply or timeout
module bus_iface
    import bus_iface_pkg::*;
#(
    parameter int TIMEOUT_CYC = REPLY_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic addr_strobe,
    input wire logic data_strobe,
    input wire logic priority_in_strobe,
    input wire logic cycle_select_n,
    input wire logic low_byte_rw_sel,
    input wire logic high_byte_rw_sel,
    input wire logic intack_in_strobe,
    input wire logic intack_active,
    input wire logic dma_grant_active,
    input wire logic bus_clear_n,
    input wire logic local_select_decode,
    input wire logic [ADDR_W-1:0] local_addr_data_bus,
    input wire logic brply_n,
    input wire logic bdin_in_n,
    input wire logic bdout_in_n,
    input wire logic bsync_in_n,
    output logic bdin_n,
    output logic bdout_n,
    output logic bwtbt_n,
    output logic bbs7_n,
    output logic cpu_cycle_type,
    output logic internal_read_flag,
    output logic internal_in_strobe,
    output logic internal_out_strobe,
    output logic byte_write_flag,
    output logic reply_received,
    output logic reply_or_timeout_n,
    output logic timeout_error,
    output logic io_page_flag,
    output logic cpu_clock_stop,
    output logic xcvr_tx_en,
    output logic xcvr_rx_lo,
    output logic xcvr_rx_hi,
    output logic xcvr_hi_en
);
    // Refuse a timeout the counter cannot serve
    initial begin
        if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) begin
            $error("bus_iface TIMEOUT_CYC out of range");
        end
    end

    // Previous samples of processor strobes for edge detection
    logic as_q, ds_q, pi_q;
    // Cycle-sync latch: high while the processor cycle is live
    logic cycle_sync_latch;
    // Disable latch: blocks address-phase BWTBT after BDOUT
    logic wr_disable;
    // Delayed reply sample
    logic delayed_reply;
    // Write sequence state
    wr_state_t state, next_state;

    // Edge decodes, all in the clk_sys domain
    wire as_rise = addr_strobe && !as_q;
    wire ds_fall = !data_strobe && ds_q;
    wire ds_rise = data_strobe && !ds_q;
    wire pi_rise = priority_in_strobe && !pi_q;
    wire drr_rise = !brply_n && !delayed_reply;
    // Both selects high means a read
    wire sel_read = low_byte_rw_sel && high_byte_rw_sel;
    // Selects differing means a byte write
    wire sel_byte = low_byte_rw_sel ^ high_byte_rw_sel;
    // I/O page: top three address bits all set
    wire io_page_hit = (local_addr_data_bus[ADDR_W-1:IO_PAGE_LSB] == IO_PAGE_TAG);
    // Address-phase BWTBT: write selected, strobe high, not yet disabled
    wire bwtbt_addr = !sel_read && data_strobe && !wr_disable && cycle_sync_latch && !dma_grant_active;
    // Timer runs while either strobe waits and no reply has come
    wire timer_run = (internal_in_strobe || internal_out_strobe) && !reply_received;
    wire timer_expired;

    // Sample strobes for edge detection
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            as_q <= 1'b0;
            ds_q <= 1'b1;
            pi_q <= 1'b0;
            delayed_reply <= 1'b0;
        end else begin
            as_q <= addr_strobe;
            ds_q <= data_strobe;
            pi_q <= priority_in_strobe;
            delayed_reply <= !brply_n;
        end
    end

    // Cycle type and cycle-sync; bus clear acts as the cycle-sync clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !bus_clear_n) begin
            cpu_cycle_type <= 1'b0;
            cycle_sync_latch <= 1'b0;
        end else begin
            if (as_rise) begin
                cpu_cycle_type <= !cycle_select_n;
                cycle_sync_latch <= !cycle_select_n && !dma_grant_active;
            end else if (drr_rise && dma_grant_active) begin
                cycle_sync_latch <= 1'b0;
            end else if (drr_rise || timeout_error) begin
                cycle_sync_latch <= 1'b0;
            end
        end
    end

    // Read flag and byte/word latch
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !cycle_sync_latch) begin
            internal_read_flag <= 1'b0;
            byte_write_flag <= 1'b0;
        end else if (ds_fall) begin
            internal_read_flag <= sel_read && !dma_grant_active;
            byte_write_flag <= !sel_read && sel_byte;
        end
    end

    // Write sequence state register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Write sequence: address phase, data phase, done
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: if (cycle_sync_latch && !sel_read) next_state = ST_ADDR;
            ST_ADDR: if (ds_fall) next_state = ST_DATA;
            // The data strobe pin is low while the processor asserts it, so the write goes out then
            ST_DATA: if (pi_rise && cpu_cycle_type && !data_strobe) next_state = ST_DONE;
            ST_DONE: if (!cycle_sync_latch) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
        if (!cycle_sync_latch) begin
            next_state = ST_IDLE;
        end
    end

    // Output strobe and disable latch, cleared with cycle-sync
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !cycle_sync_latch) begin
            internal_out_strobe <= 1'b0;
            wr_disable <= 1'b0;
        end else if (state == ST_DATA && next_state == ST_DONE) begin
            internal_out_strobe <= 1'b1;
            wr_disable <= 1'b1;
        end
    end

    // Reply and timeout status
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reply_received <= 1'b0;
            timeout_error <= 1'b0;
        end else begin
            reply_received <= !brply_n;
            if (timer_expired && brply_n) begin
                timeout_error <= 1'b1;
            end else if (as_rise) begin
                timeout_error <= 1'b0;
            end
        end
    end

    // Reply timeout counter on the module clock
    reply_timer #(
        .LIMIT(TIMEOUT_CYC)
    ) u_timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(timer_run),
        .expired(timer_expired)
    );

    // Input strobe: processor read, or intack regardless of selects
    assign internal_in_strobe = internal_read_flag || intack_in_strobe;
    // Backplane strobes, active low
    assign bdin_n = !internal_in_strobe;
    assign bdout_n = !internal_out_strobe;
    // Data phase runs from the strobe fall, before and after the output strobe
    wire bwtbt_data = (state == ST_DATA || state == ST_DONE) && byte_write_flag;
    // BWTBT: address phase of any write, data phase of byte writes only
    assign bwtbt_n = !(bwtbt_addr || bwtbt_data) || internal_read_flag;
    // Reply or timeout releases the clock and ready logic
    assign reply_or_timeout_n = !(reply_received || timeout_error);
    // Clock stopped while a data strobe waits for release
    assign cpu_clock_stop = (internal_in_strobe || internal_out_strobe) && reply_or_timeout_n;
    // I/O page during processor cycles only
    assign io_page_flag = io_page_hit && !cycle_select_n && !dma_grant_active;
    assign bbs7_n = !io_page_flag;

    // Transceiver direction; receive wins over transmit
    wire dma_local = dma_grant_active && local_select_decode && !bsync_in_n;
    wire rx_dma = dma_grant_active && !(dma_local && !bdin_in_n);
    wire rx_read = internal_read_flag && !local_select_decode && reply_received;
    wire rx_lo_raw = rx_dma || rx_read || intack_active;
    wire rx_hi_raw = (rx_dma || rx_read) && !intack_active;
    wire tx_raw = cycle_sync_latch || dma_local;
    assign xcvr_rx_lo = bus_clear_n && rx_lo_raw;
    assign xcvr_rx_hi = bus_clear_n && rx_hi_raw;
    assign xcvr_tx_en = bus_clear_n && tx_raw && !rx_lo_raw && !rx_hi_raw;
    assign xcvr_hi_en = bus_clear_n && !intack_active;

    // Timeout sets the error only after the full count without a reply
    property p_timeout_set;
        @(posedge clk_sys) disable iff (sys_rst)
        timer_expired && brply_n |=> timeout_error;
    endproperty
    a_timeout_set: assert property (p_timeout_set) else $error("timeout not flagged");

    property p_bdin_read;
        @(posedge clk_sys) disable iff (sys_rst)
        internal_read_flag |-> !bdin_n;
    endproperty
    a_bdin_read: assert property (p_bdin_read) else $error("BDIN not low on read");

    property p_rx_prio;
        @(posedge clk_sys) disable iff (sys_rst)
        (xcvr_rx_lo || xcvr_rx_hi) |-> !xcvr_tx_en;
    endproperty
    a_rx_prio: assert property (p_rx_prio) else $error("transmit with receive");

    property p_bus_clear;
        @(posedge clk_sys) disable iff (sys_rst)
        !bus_clear_n |-> !xcvr_tx_en && !xcvr_rx_lo && !xcvr_rx_hi;
    endproperty
    a_bus_clear: assert property (p_bus_clear) else $error("transceiver active in bus clear");

    property p_bbs7;
        @(posedge clk_sys) disable iff (sys_rst)
        (&local_addr_data_bus[ADDR_W-1:IO_PAGE_LSB] && !cycle_select_n && !dma_grant_active) |-> !bbs7_n && io_page_flag;
    endproperty
    a_bbs7: assert property (p_bbs7) else $error("BBS7 missing");

    property p_type_load;
        @(posedge clk_sys) disable iff (sys_rst || !bus_clear_n)
        as_rise |=> cpu_cycle_type == !$past(cycle_select_n);
    endproperty
    a_type_load: assert property (p_type_load) else $error("cycle type not loaded");

    property p_reply;
        @(posedge clk_sys) disable iff (sys_rst)
        !brply_n |=> reply_received && !reply_or_timeout_n;
    endproperty
    a_reply: assert property (p_reply) else $error("reply not seen");

    property p_intack_hi;
        @(posedge clk_sys) disable iff (sys_rst)
        intack_active |-> !xcvr_hi_en && !xcvr_rx_hi;
    endproperty
    a_intack_hi: assert property (p_intack_hi) else $error("high byte active in intack");

    property p_bdout_issue;
        @(posedge clk_sys) disable iff (sys_rst)
        (state == ST_DATA) && pi_rise && cpu_cycle_type && !data_strobe && cycle_sync_latch |=> !bdout_n;
    endproperty
    a_bdout_issue: assert property (p_bdout_issue) else $error("BDOUT not issued on priority-in");

    property p_tmo_clear;
        @(posedge clk_sys) disable iff (sys_rst)
        as_rise && !(timer_expired && brply_n) |=> !timeout_error;
    endproperty
    a_tmo_clear: assert property (p_tmo_clear) else $error("timeout error not cleared");
endmodule

// >>> test/backplane_slave.sv
/*
 * Behavioural backplane slave that answers the bridge's read and write strobes.
 * Assumes the bench ends each data phase by raising data_strobe; dma_op plays an
 * external DMA master: 0 idle, 1 sync with BDIN, 2 sync with BDOUT.
 */
`timescale 1ns/1ns
module backplane_slave (
    input wire logic clk_sys,
    input wire logic bdin_n,
    input wire logic bdout_n,
    input wire logic data_strobe,
    input wire logic mute,
    input wire logic [3:0] delay,
    input wire logic [1:0] dma_op,
    output logic brply_n,
    output logic bdin_in_n,
    output logic bdout_in_n,
    output logic bsync_in_n
);
    int wait_cnt = 0; // Cycles since a strobe was seen

    // Strobes start negated; dma_op then drives the external master's strobes
    initial begin
        brply_n = 1'b1;
        bdin_in_n = 1'b1;
        bdout_in_n = 1'b1;
        bsync_in_n = 1'b1;
    end

    // External DMA master strobes, changed just after the clock edge
    always @(posedge clk_sys) begin
        bsync_in_n <= (dma_op == 2'h0);
        bdin_in_n <= (dma_op != 2'h1);
        bdout_in_n <= (dma_op != 2'h2);
    end

    // Reply after the set delay and hold it until the master closes the data phase;
    // a muted slave never replies so the timeout can be seen
    always @(posedge clk_sys) begin
        if (data_strobe) begin
            wait_cnt <= 0;
            brply_n <= 1'b1;
        end else if (!bdin_n || !bdout_n) begin
            wait_cnt <= wait_cnt + 1;
            if (!mute && wait_cnt >= delay) begin
                brply_n <= 1'b0;
            end
        end
    end
endmodule

// >>> test/processor_backplane_bus_interface_test.sv
/*
 * Self-checking bench for the processor-to-backplane bridge: read, write, intack,
 * timeout and bus-clear cycles against a behavioural slave.
 * Assumes a short reply timeout so a missing reply shows within a few cycles.
 */
`timescale 1ns/1ns
module processor_backplane_bus_interface_test;
    import bus_iface_pkg::*;
    localparam int TMO = 8; // Shortened reply timeout
    logic clk_sys = 1'b0, sys_rst = 1'b1;
    logic addr_strobe = 1'b0, data_strobe = 1'b1, priority_in_strobe = 1'b0;
    logic cycle_select_n = 1'b1, low_byte_rw_sel = 1'b1, high_byte_rw_sel = 1'b1;
    logic intack_in_strobe = 1'b0, intack_active = 1'b0, dma_grant_active = 1'b0;
    logic bus_clear_n = 1'b1, local_select_decode = 1'b0, mute = 1'b0;
    logic [ADDR_W-1:0] local_addr_data_bus = 16'h0000;
    logic [1:0] dma_op = 2'h0;
    logic brply_n, bdin_in_n, bdout_in_n, bsync_in_n, bdin_n, bdout_n, bwtbt_n, bbs7_n;
    logic cpu_cycle_type, internal_read_flag, internal_in_strobe, internal_out_strobe;
    logic byte_write_flag, reply_received, reply_or_timeout_n, timeout_error, io_page_flag;
    logic cpu_clock_stop, xcvr_tx_en, xcvr_rx_lo, xcvr_rx_hi, xcvr_hi_en;
    int n_fail = 0, n_compared = 0;

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    bus_iface #(.TIMEOUT_CYC(TMO)) bus_iface_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .addr_strobe(addr_strobe), .data_strobe(data_strobe), .priority_in_strobe(priority_in_strobe),
        .cycle_select_n(cycle_select_n), .low_byte_rw_sel(low_byte_rw_sel), .high_byte_rw_sel(high_byte_rw_sel),
        .intack_in_strobe(intack_in_strobe), .intack_active(intack_active), .dma_grant_active(dma_grant_active),
        .bus_clear_n(bus_clear_n), .local_select_decode(local_select_decode),
        .local_addr_data_bus(local_addr_data_bus), .brply_n(brply_n), .bdin_in_n(bdin_in_n),
        .bdout_in_n(bdout_in_n), .bsync_in_n(bsync_in_n), .bdin_n(bdin_n), .bdout_n(bdout_n),
        .bwtbt_n(bwtbt_n), .bbs7_n(bbs7_n), .cpu_cycle_type(cpu_cycle_type),
        .internal_read_flag(internal_read_flag), .internal_in_strobe(internal_in_strobe),
        .internal_out_strobe(internal_out_strobe), .byte_write_flag(byte_write_flag),
        .reply_received(reply_received), .reply_or_timeout_n(reply_or_timeout_n),
        .timeout_error(timeout_error), .io_page_flag(io_page_flag), .cpu_clock_stop(cpu_clock_stop),
        .xcvr_tx_en(xcvr_tx_en), .xcvr_rx_lo(xcvr_rx_lo), .xcvr_rx_hi(xcvr_rx_hi), .xcvr_hi_en(xcvr_hi_en));

    // Slave replies late enough that strobes can be checked before the reply lands
    backplane_slave backplane_slave_i (.clk_sys(clk_sys), .bdin_n(bdin_n), .bdout_n(bdout_n),
        .data_strobe(data_strobe), .mute(mute), .delay(4'h6), .dma_op(dma_op), .brply_n(brply_n),
        .bdin_in_n(bdin_in_n), .bdout_in_n(bdout_in_n), .bsync_in_n(bsync_in_n));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Compare one observed bit with its expected value
    task automatic chk(input string name, input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask

    // Present address and selects, then raise the address strobe
    task automatic start_cycle(input logic [15:0] addr, input logic sel_n, input logic lo, input logic hi);
        @(posedge clk_sys);
        local_addr_data_bus <= addr;
        cycle_select_n <= sel_n;
        low_byte_rw_sel <= lo;
        high_byte_rw_sel <= hi;
        @(posedge clk_sys);
        addr_strobe <= 1'b1;
        cyc(4);
    endtask

    // Close the cycle the way the processor does; slave releases its reply
    task automatic end_cycle();
        data_strobe <= 1'b1;
        priority_in_strobe <= 1'b0;
        addr_strobe <= 1'b0;
        intack_in_strobe <= 1'b0;
        intack_active <= 1'b0;
        cyc(4);
    endtask

    // Common reply check once the slave has answered
    task automatic chk_reply();
        cyc(8);
        chk("reply_received", reply_received, 1'b1);
        chk("reply_or_timeout_n", reply_or_timeout_n, 1'b0);
        chk("timeout_error", timeout_error, 1'b0);
    endtask

    // Word read from the I/O page over the backplane
    task automatic t_read_io();
        start_cycle(16'hE000, 1'b0, 1'b1, 1'b1);
        chk("cpu_cycle_type", cpu_cycle_type, 1'b1);
        chk("bbs7_n", bbs7_n, 1'b0);
        chk("io_page_flag", io_page_flag, 1'b1);
        data_strobe <= 1'b0;
        cyc(4);
        chk("internal_read_flag", internal_read_flag, 1'b1);
        chk("bdin_n", bdin_n, 1'b0);
        chk("cpu_clock_stop", cpu_clock_stop, 1'b1);
        // Receive stands from the reply until cycle-sync drops the read flag
        cyc(5);
        @(negedge clk_sys);
        chk("xcvr_rx_lo", xcvr_rx_lo, 1'b1);
        chk("xcvr_rx_hi", xcvr_rx_hi, 1'b1);
        chk_reply();
        end_cycle();
    endtask

    // Write outside the I/O page; byte when selects differ
    task automatic t_write(input logic lo, input logic hi);
        start_cycle(16'h1FFE, 1'b0, lo, hi);
        chk("bwtbt_n addr phase", bwtbt_n, 1'b0);
        chk("bbs7_n", bbs7_n, 1'b1);
        data_strobe <= 1'b0;
        cyc(4);
        chk("byte_write_flag", byte_write_flag, lo ^ hi);
        chk("bwtbt_n data phase", bwtbt_n, ~(lo ^ hi));
        priority_in_strobe <= 1'b1;
        cyc(4);
        chk("internal_out_strobe", internal_out_strobe, 1'b1);
        chk("bdout_n", bdout_n, 1'b0);
        chk("xcvr_tx_en", xcvr_tx_en, 1'b1);
        chk_reply();
        end_cycle();
    endtask

    // Read with a silent slave, then a fresh cycle clears the error
    task automatic t_timeout();
        mute <= 1'b1;
        start_cycle(16'hE002, 1'b0, 1'b1, 1'b1);
        data_strobe <= 1'b0;
        cyc(4);
        chk("timeout_error early", timeout_error, 1'b0);
        cyc(TMO + 4);
        chk("timeout_error", timeout_error, 1'b1);
        chk("reply_or_timeout_n", reply_or_timeout_n, 1'b0);
        chk("cpu_clock_stop", cpu_clock_stop, 1'b0);
        end_cycle();
        mute <= 1'b0;
        start_cycle(16'hE002, 1'b0, 1'b1, 1'b1);
        chk("timeout_error cleared", timeout_error, 1'b0);
        end_cycle();
    endtask

    // Interrupt acknowledge with write-like selects
    task automatic t_intack();
        start_cycle(16'h0000, 1'b1, 1'b0, 1'b0);
        chk("cpu_cycle_type", cpu_cycle_type, 1'b0);
        intack_active <= 1'b1;
        intack_in_strobe <= 1'b1;
        data_strobe <= 1'b0;
        cyc(4);
        chk("internal_in_strobe", internal_in_strobe, 1'b1);
        chk("bdin_n", bdin_n, 1'b0);
        chk("xcvr_hi_en", xcvr_hi_en, 1'b0);
        chk("xcvr_rx_lo", xcvr_rx_lo, 1'b1);
        end_cycle();
    endtask

    // Bus clear in mid-cycle drops the cycle type and the transmitters
    task automatic t_clear();
        start_cycle(16'hE000, 1'b0, 1'b1, 1'b1);
        bus_clear_n <= 1'b0;
        cyc(3);
        chk("cpu_cycle_type", cpu_cycle_type, 1'b0);
        chk("xcvr_tx_en", xcvr_tx_en, 1'b0);
        bus_clear_n <= 1'b1;
        end_cycle();
    endtask

    // DMA by an external master: foreign address, then local read and local write
    task automatic t_dma();
        dma_grant_active <= 1'b1;
        cyc(3);
        chk("xcvr_rx_lo dma", xcvr_rx_lo, 1'b1);
        chk("xcvr_tx_en dma", xcvr_tx_en, 1'b0);
        chk("bbs7_n dma", bbs7_n, 1'b1);
        local_select_decode <= 1'b1;
        dma_op <= 2'h1;
        cyc(3);
        chk("xcvr_tx_en dma read", xcvr_tx_en, 1'b1);
        chk("xcvr_rx_lo dma read", xcvr_rx_lo, 1'b0);
        dma_op <= 2'h2;
        cyc(3);
        chk("xcvr_rx_lo dma write", xcvr_rx_lo, 1'b1);
        chk("xcvr_tx_en dma write", xcvr_tx_en, 1'b0);
        dma_op <= 2'h0;
        local_select_decode <= 1'b0;
        dma_grant_active <= 1'b0;
        cyc(2);
    endtask

    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard: all scenarios take well under 400 cycles
    initial begin
        #(50 * 3000);
        n_fail++;
        end_of_test();
    end

    // Main sequence
    initial begin
        cyc(2);
        sys_rst <= 1'b0;
        cyc(1);
        t_read_io();
        t_write(1'b0, 1'b1);
        t_write(1'b1, 1'b0);
        t_write(1'b0, 1'b0);
        t_timeout();
        t_intack();
        t_clear();
        t_dma();
        end_of_test();
    end
endmodule
